// ==== hdl/power_mode_pkg.sv ====
// Constants, register map and state encodings shared by the power mode and reset control
package power_mode_pkg;
	localparam int unsigned CLK_PERIOD_NS = 100;
	localparam int unsigned SPIKE_NS      = 50;
	localparam int unsigned SPIKE_RAW     = (SPIKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned FILT_CYCLES   = (SPIKE_RAW < 1) ? 1 : SPIKE_RAW;
	localparam int unsigned FILT_CNT_W    = 8;

	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 32;

	localparam logic [ADDR_W-1:0] OFS_CTRL      = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_STATUS    = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_WAKE      = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_FLAGS     = 8'h0C;
	localparam logic [ADDR_W-1:0] OFS_ALARM     = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_RTC_COUNT = 8'h14;

	localparam int unsigned WAKE_N        = 3;
	localparam int unsigned WAKE_UART     = 0;
	localparam int unsigned WAKE_USB      = 1;
	localparam int unsigned WAKE_CLK      = 2;
	localparam int unsigned CTRL_STOP_BIT = 0;
	localparam int unsigned CTRL_RUN_BIT  = 1;
	localparam int unsigned CTRL_ACK_BIT  = 2;
	localparam int unsigned CTRL_MASK_LSB = 4;
	localparam int unsigned STAT_REQ_BIT  = 0;
	localparam int unsigned STAT_SLOW_BIT = 1;
	localparam int unsigned STAT_SBY_BIT  = 2;
	localparam int unsigned STAT_ST_LSB   = 4;
	localparam int unsigned FLAG_DEBUG    = 0;
	localparam int unsigned FLAG_RTC      = 1;
	localparam int unsigned FLAG_N        = 2;

	localparam logic [WAKE_N-1:0] MASK_RESET  = 3'h7;
	localparam logic [DATA_W-1:0] ALARM_RESET = 32'hFFFF_FFFF;
	localparam logic [DATA_W-1:0] ZERO_WORD   = 32'h0000_0000;

	typedef enum logic [1:0] {
		ST_RUN     = 2'b00,
		ST_STOPPED = 2'b01,
		ST_SLOW    = 2'b11,
		ST_RESUME  = 2'b10
	} stop_state_e;
endpackage

// ==== hdl/power_mode_reset_control.sv ====
// Stop/standby mode control, reset filtering and reset-kept registers behind Avalon-MM
// How it works
// - Any enabled wake event drops the stop request.
// - Wake sources are UART receive, USB wake and main clock activity.
// - The stop request is a pin, so its fall tells the outside of exit.
// - After the stop request drops, the block runs in slow mode.
// - Standby exit is only through system reset; the RTC counter keeps counting.
// - Standby acknowledge is given by software only while the manager requests it.
// - System reset leaves the RTC and debug sections untouched.
// - System reset input rejects spikes below 50 ns; its one-cycle filter passes any low level seen on one edge.
// - RTC reset clears only the RTC section, with the same filtering.
// - Debug reset clears only debug logic, rejecting spikes below 50 ns; its one-cycle filter passes any level seen on one edge.
// - System reset clears every reset-cause flag.
// - System reset keeps the RTC running; power-on reset clears both.
// - Alarm registers go to all ones only on RTC reset or power-on reset.
//
// Added by the designer: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps
module power_mode_reset_control
	import power_mode_pkg::*;
(
	input  wire logic              clk_in,
	input  wire logic              resetn_in,
	input  wire logic              ce_in,
	input  wire logic              system_reset_in_n,
	input  wire logic              rtc_reset_in,
	input  wire logic              debug_reset_in,
	input  wire logic              uart_rx_wake_in,
	input  wire logic              usb_wake_in,
	input  wire logic              main_clk_active_in,
	input  wire logic              standby_request_in,
	input  wire logic              rtc_tick_in,
	input  wire logic [ADDR_W-1:0] avs_address_in,
	input  wire logic              avs_read_in,
	input  wire logic              avs_write_in,
	input  wire logic [DATA_W-1:0] avs_writedata_in,
	output logic      [DATA_W-1:0] avs_readdata_out,
	output logic                   avs_waitrequest_out,
	output logic                   stop_req_out,
	output logic                   slow_mode_out,
	output logic                   standby_ack_out,
	output logic                   system_reset_out,
	output logic                   rtc_reset_out,
	output logic                   debug_reset_out
);
	logic              sys_ok;
	logic              rtc_idle;
	logic              dbg_idle;
	logic              sys_rst_r;
	logic              rtc_rst_r;
	logic              dbg_rst_r;
	logic              req;
	logic              ack_r;
	logic              ack_nxt;
	logic [DATA_W-1:0] rdata_r;
	logic [DATA_W-1:0] rdata_nxt;
	logic              wr;
	stop_state_e       state_r;
	stop_state_e       state_nxt;
	logic              stop_req_r;
	logic              stop_req_nxt;
	logic              slow_r;
	logic              slow_nxt;
	logic [WAKE_N-1:0] mask_r;
	logic [WAKE_N-1:0] mask_nxt;
	logic              sby_ack_r;
	logic              sby_ack_nxt;
	logic [WAKE_N-1:0] cause_r;
	logic [WAKE_N-1:0] cause_nxt;
	logic [FLAG_N-1:0] flags_r;
	logic [FLAG_N-1:0] flags_nxt;
	logic [WAKE_N-1:0] wake_src;
	logic              wake;
	logic [DATA_W-1:0] alarm_r;
	logic [DATA_W-1:0] alarm_nxt;
	logic [DATA_W-1:0] count_r;
	logic [DATA_W-1:0] count_nxt;

	function automatic logic hit(input logic [ADDR_W-1:0] ofs);
		return wr && (avs_address_in == ofs);
	endfunction

	reset_filter u_sys_filter (
		.clk_in     (clk_in),
		.resetn_in  (resetn_in),
		.ce_in      (ce_in),
		.level_in   (system_reset_in_n),
		.active_out (sys_ok)
	);

	reset_filter u_rtc_filter (
		.clk_in     (clk_in),
		.resetn_in  (resetn_in),
		.ce_in      (ce_in),
		.level_in   (!rtc_reset_in),
		.active_out (rtc_idle)
	);

	reset_filter u_dbg_filter (
		.clk_in     (clk_in),
		.resetn_in  (resetn_in),
		.ce_in      (ce_in),
		.level_in   (!debug_reset_in),
		.active_out (dbg_idle)
	);

	// Filtered resets, registered once more for the outputs
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			sys_rst_r <= 1'b1;
			rtc_rst_r <= 1'b1;
			dbg_rst_r <= 1'b1;
		end else if (ce_in) begin
			sys_rst_r <= !sys_ok;
			rtc_rst_r <= !rtc_idle;
			dbg_rst_r <= !dbg_idle;
		end
	end

	// Avalon slave: one wait cycle; a write commits where waitrequest is low
	assign req = (avs_read_in || avs_write_in) && !sys_rst_r;
	assign wr  = avs_write_in && req && ack_r;

	always_comb begin
		ack_nxt   = req && !ack_r;
		rdata_nxt = rdata_r;
		if (req && !ack_r) begin
			unique case (avs_address_in)
				OFS_CTRL:      rdata_nxt = DATA_W'({mask_r, 1'b0, sby_ack_r, 2'b00});
				OFS_STATUS:    rdata_nxt = DATA_W'({state_r, 1'b0, standby_request_in,
					slow_r, stop_req_r});
				OFS_WAKE:      rdata_nxt = DATA_W'(cause_r);
				OFS_FLAGS:     rdata_nxt = DATA_W'(flags_r);
				OFS_ALARM:     rdata_nxt = alarm_r;
				OFS_RTC_COUNT: rdata_nxt = count_r;
				default:       rdata_nxt = ZERO_WORD;
			endcase
		end
	end

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			ack_r   <= 1'b0;
			rdata_r <= ZERO_WORD;
		end else if (ce_in) begin
			ack_r   <= ack_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	// Stop mode, wake-up and standby handshake
	assign wake_src = {main_clk_active_in, usb_wake_in, uart_rx_wake_in};
	assign wake     = |(wake_src & mask_r);

	always_comb begin
		state_nxt    = state_r;
		stop_req_nxt = stop_req_r;
		slow_nxt     = slow_r;
		mask_nxt     = mask_r;
		sby_ack_nxt  = sby_ack_r && standby_request_in;
		cause_nxt    = cause_r;
		flags_nxt    = flags_r;
		if (hit(OFS_CTRL)) begin
			mask_nxt    = avs_writedata_in[CTRL_MASK_LSB +: WAKE_N];
			sby_ack_nxt = avs_writedata_in[CTRL_ACK_BIT] && standby_request_in;
		end
		if (hit(OFS_WAKE)) begin
			cause_nxt = cause_r & ~avs_writedata_in[WAKE_N-1:0];
		end
		if (hit(OFS_FLAGS)) begin
			flags_nxt = flags_r & ~avs_writedata_in[FLAG_N-1:0];
		end
		if (dbg_rst_r) begin
			flags_nxt[FLAG_DEBUG] = 1'b1;
		end
		if (rtc_rst_r) begin
			flags_nxt[FLAG_RTC] = 1'b1;
		end
		unique case (state_r)
			ST_RUN: begin
				if (hit(OFS_CTRL) && avs_writedata_in[CTRL_STOP_BIT]) begin
					state_nxt    = ST_STOPPED;
					stop_req_nxt = 1'b1;
					slow_nxt     = 1'b1;
				end
			end
			ST_STOPPED: begin
				if (wake) begin
					state_nxt    = ST_SLOW;
					stop_req_nxt = 1'b0;
					slow_nxt     = 1'b1;
					cause_nxt    = cause_nxt | (wake_src & mask_r);
				end
			end
			ST_SLOW: begin
				if (hit(OFS_CTRL) && avs_writedata_in[CTRL_RUN_BIT]) begin
					state_nxt = ST_RESUME;
				end
			end
			ST_RESUME: begin
				state_nxt = ST_RUN;
				slow_nxt  = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			state_r    <= ST_RUN;
			stop_req_r <= 1'b0;
			slow_r     <= 1'b0;
			mask_r     <= MASK_RESET;
			sby_ack_r  <= 1'b0;
			cause_r    <= '0;
			flags_r    <= '0;
		end else if (ce_in) begin
			if (sys_rst_r) begin
				state_r    <= ST_RUN;
				stop_req_r <= 1'b0;
				slow_r     <= 1'b0;
				mask_r     <= MASK_RESET;
				sby_ack_r  <= 1'b0;
				cause_r    <= '0;
				flags_r    <= '0;
			end else begin
				state_r    <= state_nxt;
				stop_req_r <= stop_req_nxt;
				slow_r     <= slow_nxt;
				mask_r     <= mask_nxt;
				sby_ack_r  <= sby_ack_nxt;
				cause_r    <= cause_nxt;
				flags_r    <= flags_nxt;
			end
		end
	end

	// RTC section: only the RTC reset or power-on touches it
	always_comb begin
		alarm_nxt = alarm_r;
		count_nxt = count_r;
		if (rtc_rst_r) begin
			alarm_nxt = ALARM_RESET;
			count_nxt = ZERO_WORD;
		end else begin
			if (hit(OFS_ALARM)) begin
				alarm_nxt = avs_writedata_in;
			end
			if (rtc_tick_in) begin
				count_nxt = count_r + 1'b1;
			end
		end
	end

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			alarm_r <= ALARM_RESET;
			count_r <= ZERO_WORD;
		end else if (ce_in) begin
			alarm_r <= alarm_nxt;
			count_r <= count_nxt;
		end
	end

	assign avs_readdata_out    = rdata_r;
	assign avs_waitrequest_out = !ack_r;
	assign stop_req_out        = stop_req_r;
	assign slow_mode_out       = slow_r;
	assign standby_ack_out     = sby_ack_r;
	assign system_reset_out    = sys_rst_r;
	assign rtc_reset_out       = rtc_rst_r;
	assign debug_reset_out     = dbg_rst_r;

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!resetn_in);

	wake_drops_req_a: assert property (ce_in && !sys_rst_r && state_r == ST_STOPPED && wake
		|=> !stop_req_out) else $error("Stop request held after wake event");
	wake_slow_mode_a: assert property (ce_in && !sys_rst_r && state_r == ST_STOPPED && wake
		|=> slow_mode_out && state_r == ST_SLOW) else $error("No slow mode after wake");
	req_fall_slow_a: assert property ($fell(stop_req_out) && !sys_rst_r |-> slow_mode_out)
		else $error("Stop request fell without slow mode");
	flags_cleared_a: assert property (ce_in && sys_rst_r |=> flags_r == '0)
		else $error("Reset flags not cleared by system reset");
	alarm_kept_a: assert property (ce_in && sys_rst_r && !rtc_rst_r && !wr
		|=> $stable(alarm_r)) else $error("Alarm changed on system reset");
	alarm_ones_a: assert property (ce_in && rtc_rst_r |=> alarm_r == ALARM_RESET)
		else $error("Alarm not set to all ones on RTC reset");
	count_runs_a: assert property (ce_in && sys_rst_r && !rtc_rst_r && rtc_tick_in
		|=> count_r == $past(count_r) + 1'b1) else $error("RTC stopped on system reset");
	ack_dropped_a: assert property (ce_in && sys_rst_r |=> !standby_ack_out)
		else $error("Standby acknowledge survived system reset");
	ack_needs_req_a: assert property (standby_ack_out && $past(ce_in)
		|-> $past(standby_request_in))
		else $error("Standby acknowledge without request");
	bus_answer_a: assert property (ce_in && req && avs_waitrequest_out
		|=> !avs_waitrequest_out) else $error("Bus request not answered");

	stop_wake_c: cover property (state_r == ST_STOPPED ##1 state_r == ST_SLOW);
	standby_c: cover property (standby_request_in ##1 standby_ack_out);
	rtc_reset_c: cover property (rtc_reset_out ##1 !rtc_reset_out);
endmodule

// ==== hdl/reset_filter.sv ====
// Spike filter and release synchroniser for one reset input
`timescale 1ns/1ps
module reset_filter
	import power_mode_pkg::*;
#(
	parameter int unsigned HOLD_CYCLES = FILT_CYCLES
) (
	input  wire logic clk_in,
	input  wire logic resetn_in,
	input  wire logic ce_in,
	input  wire logic level_in,
	output logic      active_out
);
	localparam logic [FILT_CNT_W-1:0] HOLD = FILT_CNT_W'(HOLD_CYCLES);

	logic                  sync1_r;
	logic                  sync2_r;
	logic [FILT_CNT_W-1:0] cnt_r;
	logic [FILT_CNT_W-1:0] cnt_nxt;
	logic                  active_r;
	logic                  active_nxt;

	always_comb begin
		cnt_nxt    = '0;
		active_nxt = active_r;
		if (sync2_r != active_r) begin
			cnt_nxt = cnt_r + 1'b1;
			if (cnt_r + 1'b1 >= HOLD) begin
				active_nxt = sync2_r;
				cnt_nxt    = '0;
			end
		end
	end

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			// Come up asserted so every reset leaves only through the synchroniser
			sync1_r  <= 1'b0;
			sync2_r  <= 1'b0;
			cnt_r    <= '0;
			active_r <= 1'b0;
		end else if (ce_in) begin
			sync1_r  <= level_in;
			sync2_r  <= sync1_r;
			cnt_r    <= cnt_nxt;
			active_r <= active_nxt;
		end
	end

	assign active_out = active_r;

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!resetn_in);

	filter_change_a: assert property ($changed(active_r) |-> $past(sync2_r) == active_r)
		else $error("Filter output changed without a settled input");
endmodule

// ==== sim/power_manager_model.sv ====
// External power manager model driving the reset pin, standby request and main clock line
`timescale 1ns/1ps
module power_manager_model #(
	parameter int unsigned HOLD_CYCLES = 20
) (
	input  wire logic clk_in,
	input  wire logic resetn_in,
	input  wire logic stop_req_in,
	input  wire logic standby_ack_in,
	input  wire logic standby_go_in,
	input  wire logic clk_restart_in,
	output logic      system_reset_n_out,
	output logic      standby_request_out,
	output logic      main_clk_active_out
);
	// Reset hold stands in for the scaled power-up and supply settling times
	logic [7:0] hold_r;
	logic       stop_q_r;

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			system_reset_n_out  <= 1'b0;
			standby_request_out <= 1'b0;
			main_clk_active_out <= 1'b0;
			hold_r              <= 8'(HOLD_CYCLES);
			stop_q_r            <= 1'b0;
		end else begin
			if (hold_r != 8'h00) begin
				hold_r             <= hold_r - 8'h01;
				system_reset_n_out <= (hold_r == 8'h01);
			end else if (standby_request_out && standby_ack_in) begin
				system_reset_n_out  <= 1'b0;
				standby_request_out <= 1'b0;
				hold_r              <= 8'(HOLD_CYCLES);
			end else begin
				standby_request_out <= standby_go_in;
			end
			if (stop_req_in && !stop_q_r) begin
				main_clk_active_out <= 1'b0;
			end else if ((stop_q_r && !stop_req_in) || clk_restart_in) begin
				main_clk_active_out <= 1'b1;
			end
			stop_q_r <= stop_req_in;
		end
	end
endmodule

// ==== sim/testbench.sv ====
// Self-checking bench for stop, standby and reset handling
`timescale 1ns/1ps
module testbench
	import power_mode_pkg::*;
;
	logic              clk_in = 1'b0;
	logic              resetn_in, rtc_reset_in, debug_reset_in, uart_rx_wake_in, usb_wake_in;
	logic              rtc_tick_in, avs_read_in, avs_write_in, standby_go, clk_restart;
	logic [ADDR_W-1:0] avs_address_in;
	logic [DATA_W-1:0] avs_writedata_in, avs_readdata_out, d;
	logic              avs_waitrequest_out, stop_req_out, slow_mode_out, standby_ack_out;
	logic              system_reset_out, rtc_reset_out, debug_reset_out;
	logic              sys_n, sby_req, main_clk;
	int                err_count = 0;
	int                n_tests = 0;
	int                cyc = 0;
	int                i;

	always #50 clk_in = ~clk_in;

	power_mode_reset_control power_mode_reset_control_inst (.clk_in(clk_in),
		.resetn_in(resetn_in), .ce_in(1'b1), .system_reset_in_n(sys_n),
		.rtc_reset_in(rtc_reset_in), .debug_reset_in(debug_reset_in),
		.uart_rx_wake_in(uart_rx_wake_in), .usb_wake_in(usb_wake_in),
		.main_clk_active_in(main_clk), .standby_request_in(sby_req), .rtc_tick_in(rtc_tick_in),
		.avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
		.avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
		.avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
		.stop_req_out(stop_req_out), .slow_mode_out(slow_mode_out),
		.standby_ack_out(standby_ack_out), .system_reset_out(system_reset_out),
		.rtc_reset_out(rtc_reset_out), .debug_reset_out(debug_reset_out));

	power_manager_model power_manager_model_inst (.clk_in(clk_in), .resetn_in(resetn_in),
		.stop_req_in(stop_req_out), .standby_ack_in(standby_ack_out),
		.standby_go_in(standby_go), .clk_restart_in(clk_restart),
		.system_reset_n_out(sys_n), .standby_request_out(sby_req), .main_clk_active_out(main_clk));

	task automatic end_sim();
		if (err_count == 0 && n_tests > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	always @(posedge clk_in) begin
		cyc++;
		if (cyc == 5000) begin
			err_count++;
			end_sim();
		end
	end

	task automatic check(input string what, input logic [DATA_W-1:0] seen, exp);
		n_tests++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] wd);
		avs_address_in   <= a;
		avs_writedata_in <= wd;
		avs_write_in     <= wr;
		avs_read_in      <= ~wr;
		do @(posedge clk_in); while (avs_waitrequest_out !== 1'b0);
		d = avs_readdata_out;
		avs_write_in <= 1'b0;
		avs_read_in  <= 1'b0;
		@(posedge clk_in);
	endtask

	// Pin select: 0 usb wake, 1 rtc tick, 2 debug reset, 3 rtc reset
	task automatic drive(input int sel, input logic v);
		case (sel)
			0: usb_wake_in <= v;
			1: rtc_tick_in <= v;
			2: debug_reset_in <= v;
			default: rtc_reset_in <= v;
		endcase
	endtask

	task automatic pulse(input int sel, input int n);
		drive(sel, 1'b1);
		repeat (n) @(posedge clk_in);
		drive(sel, 1'b0);
		@(posedge clk_in);
	endtask

	task automatic test_reset_values();
		bus(1'b0, OFS_ALARM, ZERO_WORD);
		check("alarm", d, ALARM_RESET);
		bus(1'b0, OFS_FLAGS, ZERO_WORD);
		check("flags", d, ZERO_WORD);
	endtask

	task automatic test_stop_wake(input int src);
		logic [DATA_W-1:0] m;
		m = 32'h1 << src;
		bus(1'b1, OFS_CTRL, (m << CTRL_MASK_LSB) | 32'h1);
		check("stop_req", 32'(stop_req_out), 32'h1);
		if (src == WAKE_UART) begin
			pulse(0, 3);
			check("masked", 32'(stop_req_out), 32'h1);
		end
		if (src == WAKE_CLK) clk_restart <= 1'b1;
		if (src == WAKE_UART) uart_rx_wake_in <= 1'b1;
		if (src == WAKE_USB) usb_wake_in <= 1'b1;
		for (i = 0; i < 20 && stop_req_out !== 1'b0; i++) @(posedge clk_in);
		clk_restart     <= 1'b0;
		uart_rx_wake_in <= 1'b0;
		usb_wake_in     <= 1'b0;
		check("stop_req", 32'(stop_req_out), 32'h0);
		check("slow", 32'(slow_mode_out), 32'h1);
		bus(1'b0, OFS_STATUS, ZERO_WORD);
		check("status", d, 32'h32);
		repeat (3) @(posedge clk_in);
		bus(1'b0, OFS_WAKE, ZERO_WORD);
		check("cause", d, m);
		bus(1'b1, OFS_WAKE, m);
		bus(1'b1, OFS_CTRL, (m << CTRL_MASK_LSB) | 32'h2);
		@(posedge clk_in);
		check("slow", 32'(slow_mode_out), 32'h0);
	endtask

	task automatic test_standby();
		bus(1'b1, OFS_ALARM, 32'h1234_5678);
		repeat (5) pulse(1, 1);
		pulse(2, 6);
		check("dbgrst", 32'(debug_reset_out), 32'h1);
		for (i = 0; i < 20 && debug_reset_out !== 1'b0; i++) @(posedge clk_in);
		bus(1'b0, OFS_FLAGS, ZERO_WORD);
		check("flags", d, 32'h1);
		bus(1'b1, OFS_CTRL, 32'h74);
		check("ack", 32'(standby_ack_out), 32'h0);
		standby_go <= 1'b1;
		repeat (3) @(posedge clk_in);
		bus(1'b1, OFS_CTRL, 32'h74);
		standby_go <= 1'b0;
		for (i = 0; i < 30 && system_reset_out !== 1'b1; i++) @(posedge clk_in);
		check("sysrst", 32'(system_reset_out), 32'h1);
		check("others", {30'h0, rtc_reset_out, debug_reset_out}, 32'h0);
		for (i = 0; i < 60 && system_reset_out !== 1'b0; i++) @(posedge clk_in);
		check("ack", 32'(standby_ack_out), 32'h0);
		bus(1'b0, OFS_ALARM, ZERO_WORD);
		check("alarm", d, 32'h1234_5678);
		bus(1'b0, OFS_RTC_COUNT, ZERO_WORD);
		check("count", d, 32'h5);
		bus(1'b0, OFS_FLAGS, ZERO_WORD);
		check("flags", d, ZERO_WORD);
		bus(1'b0, OFS_CTRL, ZERO_WORD);
		check("ctrl", d, 32'h70);
	endtask

	task automatic test_rtc_reset();
		rtc_reset_in <= 1'b1;
		for (i = 0; i < 20 && rtc_reset_out !== 1'b1; i++) @(posedge clk_in);
		check("sysrst", {30'h0, rtc_reset_out, system_reset_out}, 32'h2);
		pulse(3, 1);
		for (i = 0; i < 20 && rtc_reset_out !== 1'b0; i++) @(posedge clk_in);
		bus(1'b0, OFS_ALARM, ZERO_WORD);
		check("alarm", d, ALARM_RESET);
		bus(1'b0, OFS_RTC_COUNT, ZERO_WORD);
		check("count", d, ZERO_WORD);
		bus(1'b0, OFS_FLAGS, ZERO_WORD);
		check("flags", d, 32'h2);
	endtask

	initial begin
		{resetn_in, rtc_reset_in, debug_reset_in, uart_rx_wake_in, usb_wake_in} = 5'h00;
		{rtc_tick_in, avs_read_in, avs_write_in, standby_go, clk_restart} = 5'h00;
		avs_address_in   = 8'h00;
		avs_writedata_in = 32'h0000_0000;
		repeat (3) @(posedge clk_in);
		resetn_in <= 1'b1;
		for (i = 0; i < 60 && system_reset_out !== 1'b0; i++) @(posedge clk_in);
		check("sysrst", 32'(system_reset_out), 32'h0);
		test_reset_values();
		test_stop_wake(WAKE_CLK);
		test_stop_wake(WAKE_UART);
		test_stop_wake(WAKE_USB);
		test_standby();
		test_rtc_reset();
		end_sim();
	end
endmodule
